//--- rtl/cpg_guard.sv
// Mode control and dominant-guard logic of a CAN transceiver.
// Assumes pins arrive asynchronously; bus driver is outside this module.
`timescale 1ns/100ps
module cpg_guard
  import cpg_pkg::*;
#(
  parameter int unsigned DOM_TIMEOUT = DOM_TIMEOUT_CYC,
  parameter int unsigned UV_DELAY = UV_DELAY_CYC,
  parameter int unsigned REL_CYC = TXD_RELEASE_CYC
) (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic txd_pin, // Transmit input, low is dominant
  input wire logic receive_only_select, // High requests receive-only
  input wire logic transmitter_supply_undervoltage, // Supply below threshold
  input wire logic over_temp_pin, // Die overtemperature flag
  input wire logic bus_rx_pin, // Receiver comparator, low is dominant
  output logic drive_dominant, // Drive bus dominant
  output logic rxd_out, // Receive output to controller
  output logic tx_enabled, // Transmitter stage enabled
  output cpg_mode_t mode, // Present operating mode
  output cpg_fault_t faults // Live fault flags
);

  localparam int unsigned TW = $clog2(DOM_TIMEOUT + 1);
  localparam int unsigned UW = $clog2(UV_DELAY + 1);
  localparam int unsigned RW = $clog2(REL_CYC + 1);

  // Saturating increment of a count toward a limit
  function automatic logic [31:0] sat_inc(input logic [31:0] v,
                                          input logic [31:0] lim);
    sat_inc = (v >= lim) ? lim : v + 32'h0000_0001;
  endfunction

  typedef struct packed {
    cpg_mode_t mode;
    logic [TW-1:0] dom_cnt;
    logic [UW-1:0] uv_cnt;
    logic [RW-1:0] rel_cnt;
    logic dom_to;
    logic drive;
    logic rxd;
    logic txen;
    cpg_fault_t flt;
  } cpg_state_t;

  cpg_state_t st_q;
  cpg_state_t st_d;
  logic [4:0] pins_s;
  logic txd_s;
  logic rm_s;
  logic uv_s;
  logic ot_s;
  logic rx_s;

  // Two-flop synchronisers for all pins
  cpg_sync #(.W(5)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({txd_pin, receive_only_select, transmitter_supply_undervoltage,
             over_temp_pin, bus_rx_pin}),
    .rst_val(5'h1f),
    .sync_out(pins_s)
  );

  assign {txd_s, rm_s, uv_s, ot_s, rx_s} = pins_s;

  // Next-state logic
  always_comb
  begin
    logic tx_ok;
    tx_ok = 1'b0;
    st_d = st_q;
    // Receiver always passes bus data, any mode
    st_d.rxd = rx_s;
    // Dominant timer depends only on transmit input, not select
    if (!txd_s)
    begin
      st_d.rel_cnt = '0;
      st_d.dom_cnt = TW'(sat_inc(32'(st_q.dom_cnt), DOM_TIMEOUT));
      // Full time-out length passes before the cut
      if (32'(st_q.dom_cnt) >= DOM_TIMEOUT)
      begin
        st_d.dom_to = 1'b1;
      end
    end
    else
    begin
      st_d.rel_cnt = RW'(sat_inc(32'(st_q.rel_cnt), REL_CYC));
      if (32'(st_q.rel_cnt) + 32'h1 >= REL_CYC)
      begin
        st_d.dom_cnt = '0;
        st_d.dom_to = 1'b0;
      end
    end
    // Undervoltage persistence counter
    if (uv_s)
    begin
      st_d.uv_cnt = UW'(sat_inc(32'(st_q.uv_cnt), UV_DELAY));
    end
    else
    begin
      st_d.uv_cnt = '0;
    end
    // Mode machine
    case (st_q.mode)
      CPG_NORMAL, CPG_RX_ONLY:
      begin
        if (uv_s && 32'(st_q.uv_cnt) >= UV_DELAY)
        begin
          st_d.mode = CPG_FORCED_RX;
        end
        else
        begin
          st_d.mode = rm_s ? CPG_RX_ONLY : CPG_NORMAL;
        end
      end
      CPG_FORCED_RX:
      begin
        if (!uv_s)
        begin
          st_d.mode = rm_s ? CPG_RX_ONLY : CPG_NORMAL;
        end
      end
      default:
      begin
        st_d.mode = CPG_FORCED_RX;
      end
    endcase
    // Transmitter gate: any fault or non-normal mode blocks it
    tx_ok = (st_d.mode == CPG_NORMAL) && !uv_s && !ot_s && !st_d.dom_to;
    st_d.txen = tx_ok;
    st_d.drive = tx_ok && !txd_s;
    st_d.flt.dom_timeout = st_d.dom_to;
    st_d.flt.supply_uv = uv_s;
    st_d.flt.over_temp = ot_s;
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q.mode <= CPG_FORCED_RX;
      st_q.dom_cnt <= '0;
      st_q.uv_cnt <= '0;
      st_q.rel_cnt <= '0;
      st_q.dom_to <= 1'b0;
      st_q.drive <= 1'b0;
      st_q.rxd <= 1'b1;
      st_q.txen <= 1'b0;
      st_q.flt <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign drive_dominant = st_q.drive;
  assign rxd_out = st_q.rxd;
  assign tx_enabled = st_q.txen;
  assign mode = st_q.mode;
  assign faults = st_q.flt;

  // Dominant output only with transmitter enabled
  AST_DRIVE_GATED: assert property (
    @(posedge sys_clk) disable iff (rst)
    drive_dominant |-> tx_enabled)
    else $error("dominant driven with transmitter off");

  // Forced mode never enables transmitter
  AST_FORCED_NO_TX: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == CPG_FORCED_RX) |-> !tx_enabled)
    else $error("transmitter on in forced receive");

  // Receive output follows the bus three cycles later
  AST_RX_PASS: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##3 rxd_out == $past(bus_rx_pin, 3))
    else $error("receive output does not follow bus");

  // Supply undervoltage blocks transmitter next cycle
  AST_UV_IMMEDIATE: assert property (
    @(posedge sys_clk) disable iff (rst)
    uv_s |=> !tx_enabled)
    else $error("transmitter on during undervoltage");

  // Overtemperature blocks transmitter
  AST_OT_OFF: assert property (
    @(posedge sys_clk) disable iff (rst)
    ot_s |=> !tx_enabled && !drive_dominant)
    else $error("transmitter on during overtemperature");

  // Forced mode entry requires persisted undervoltage
  AST_UV_DELAY: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode != CPG_FORCED_RX) ##1 (mode == CPG_FORCED_RX)
      |-> 32'($past(st_q.uv_cnt)) >= UV_DELAY)
    else $error("forced mode entered too early");

  // Recovery leaves forced mode in one cycle
  AST_RECOVER: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == CPG_FORCED_RX && !uv_s) |=> (mode != CPG_FORCED_RX))
    else $error("no recovery from forced mode");

  // Time-out flag never raised before the full least duration
  AST_TO_MIN: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(st_q.dom_to) |-> 32'($past(st_q.dom_cnt)) >= DOM_TIMEOUT)
    else $error("time-out before least duration");

  // Time-out releases the bus
  AST_TO_RELEASE: assert property (
    @(posedge sys_clk) disable iff (rst)
    st_q.dom_to |-> !drive_dominant)
    else $error("bus held dominant after time-out");

  // Normal mode, no fault: dominant follows transmit input
  AST_NORMAL_FOLLOW: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st_d.mode == CPG_NORMAL && !uv_s && !ot_s && !st_d.dom_to && !txd_s)
      |=> drive_dominant)
    else $error("normal mode fails to drive dominant");

endmodule // cpg_guard

//--- rtl/cpg_pkg.sv
// Constants and carrier types for the CAN transceiver mode and guard logic.
// Assumes a single 125 MHz clock; pins are synchronised inside the block.
//
// How it works
// - With supply low or off, bus data still reaches rx at up to 5 Mbit/s.
// - Forced-receive-only holds the transmitter off so the bus is released.
// - Supply back above threshold returns the block to normal, or to receive-only if the select input is high.
// - Transmit held dominant past the time-out disables the transmitter.
// - The time-out is at least 1 ms, so shorter dominant phases pass.
// - The timer clears only after 200 ns of recessive transmit input.
// - The receive-only select input never changes the dominant timer state.
// - Overtemperature turns the transmitter off while reception goes on.
// - Forced-receive-only follows reset, and otherwise only undervoltage longer than the delay.
// - Undervoltage disables the transmitter at once, before the mode change.
package cpg_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;
  // Dominant time-out, least value in microseconds
  localparam int unsigned DOM_TIMEOUT_US = 1000;
  localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
  // Recessive time needed to clear the timer, in nanoseconds
  localparam int unsigned TXD_RELEASE_NS = 200;
  localparam int unsigned TXD_RELEASE_CYC =
    (TXD_RELEASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Undervoltage persistence before forced-receive-only, in microseconds
  localparam int unsigned UV_DELAY_US = 100;
  localparam int unsigned UV_DELAY_CYC = UV_DELAY_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    CPG_NORMAL = 2'b00,
    CPG_RX_ONLY = 2'b01,
    CPG_FORCED_RX = 2'b10
  } cpg_mode_t;

  // Fault flags reported outward
  typedef struct packed {
    logic dom_timeout;
    logic supply_uv;
    logic over_temp;
  } cpg_fault_t;

endpackage

//--- rtl/cpg_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes inputs come from pins outside the sys_clk domain.
`timescale 1ns/100ps
module cpg_sync #(
  parameter int unsigned W = 4
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [W-1:0] pin_in, // Raw pin levels
  input wire logic [W-1:0] rst_val, // Unused at reset, kept for sizing
  output logic [W-1:0] sync_out // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cpg_sync_st_t;

  cpg_sync_st_t st_q;
  cpg_sync_st_t st_d;

  // Next state: first stage feeds only the second
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end

  // Registers, reset to recessive/idle ones
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;
endmodule // cpg_sync

//--- test/can_phy_mode_and_dominant_guard_tb.sv
// Testbench for the transceiver mode control and dominant guard.
// Assumes short time-out and undervoltage delay set below.
`timescale 1ns/100ps
module can_phy_mode_and_dominant_guard_tb;
  import cpg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_bit = 1'b1;
  logic reg_on = 1'b1;
  logic rm = 1'b0;
  logic ot = 1'b0;
  logic bus = 1'b1;
  logic txd, uv, dd, rxd, txen;
  cpg_mode_t mode;
  cpg_fault_t flt;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // Clock of 8 ns
  always #4 sys_clk = ~sys_clk;
  cpg_mcu_model mcu (.tx_bit(tx_bit),
    .reg_on(reg_on), .txd_pin(txd), .supply_uv(uv));
  cpg_guard #(.DOM_TIMEOUT(50), .UV_DELAY(20)) uut (.sys_clk(sys_clk),
    .rst(rst), .txd_pin(txd), .receive_only_select(rm),
    .transmitter_supply_undervoltage(uv), .over_temp_pin(ot),
    .bus_rx_pin(bus), .drive_dominant(dd), .rxd_out(rxd),
    .tx_enabled(txen), .mode(mode), .faults(flt));
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [2:0] seen,
    input logic [2:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Receive output follows the bus both ways
  task automatic rx_follows(input string nm);
    bus = 1'b0;
    w(6);
    chk(nm, rxd, 3'h0);
    bus = 1'b1;
    w(6);
    chk(nm, rxd, 3'h1);
  endtask
  // Dominant passes, times out, clears only after a long recessive
  // Dominant seen from 3 cycles after the fall until the cut 50 cycles later, off for 4 cycles in receive-only
  task automatic t_timeout();
    tx_bit = 1'b0;
    w(20);
    rm = 1'b1;
    w(4);
    chk("rm_mode", {1'b0, mode}, {1'b0, CPG_RX_ONLY});
    chk("rm_dom", dd, 3'h0);
    rm = 1'b0;
    w(16);
    chk("dom_before", dd, 3'h1);
    w(12);
    chk("dom_edge", dd, 3'h1);
    w(1);
    chk("dom_cut", dd, 3'h0);
    w(7);
    chk("dom_after", dd, 3'h0);
    chk("to_flag", flt.dom_timeout, 3'h1);
    tx_bit = 1'b1;
    w(TXD_RELEASE_CYC - 1);
    tx_bit = 1'b0;
    w(6);
    chk("short_rel", dd, 3'h0);
    tx_bit = 1'b1;
    w(TXD_RELEASE_CYC);
    tx_bit = 1'b0;
    w(6);
    chk("long_rel", dd, 3'h1);
    chk("to_clr", flt.dom_timeout, 3'h0);
    tx_bit = 1'b1;
    w(6);
    chk("recessive", dd, 3'h0);
  endtask
  // Undervoltage: transmitter off at once, mode change after delay
  task automatic t_uv();
    reg_on = 1'b0;
    w(6);
    chk("uv_txen", txen, 3'h0);
    chk("uv_mode", {1'b0, mode}, {1'b0, CPG_NORMAL});
    chk("uv_flag", flt.supply_uv, 3'h1);
    w(16);
    chk("uv_hold", {1'b0, mode}, {1'b0, CPG_NORMAL});
    w(1);
    chk("frx_mode", {1'b0, mode}, {1'b0, CPG_FORCED_RX});
    tx_bit = 1'b0;
    w(6);
    chk("frx_dom", dd, 3'h0);
    rx_follows("frx_rxd");
    reg_on = 1'b1;
    w(6);
    chk("rec_mode", {1'b0, mode}, {1'b0, CPG_NORMAL});
    chk("rec_dom", dd, 3'h1);
    tx_bit = 1'b1;
    w(30);
  endtask
  // Overtemperature disables transmit only while present
  task automatic t_ot();
    tx_bit = 1'b0;
    ot = 1'b1;
    w(6);
    chk("ot_dom", dd, 3'h0);
    chk("ot_flag", flt.over_temp, 3'h1);
    rx_follows("ot_rxd");
    ot = 1'b0;
    w(6);
    chk("ot_clr", dd, 3'h1);
    tx_bit = 1'b1;
    w(30);
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    w(10);
    chk("rst_dom", dd, 3'h0);
    chk("rst_rxd", rxd, 3'h1);
    w(2);
    rst = 1'b0;
    w(8);
    chk("up_mode", {1'b0, mode}, {1'b0, CPG_NORMAL});
    t_timeout();
    t_uv();
    t_ot();
    results();
  end
endmodule // can_phy_mode_and_dominant_guard_tb

//--- test/cpg_mcu_model.sv
// Protocol controller model: drives transmit, switches the regulator.
// Assumes the bench gives the bit and regulator state each cycle.
`timescale 1ns/100ps
module cpg_mcu_model (
  input wire logic tx_bit, // Bit the controller sends
  input wire logic reg_on, // Regulator enable
  output logic txd_pin, // Transmit pin, low is dominant
  output logic supply_uv // Supply below threshold
);
  // Pins follow the bench's falling-edge changes at once, no race
  // Bench holds high phases long enough to clear the timer, except the short_rel phase
  // Regulator off means supply low
  always_comb
  begin
    txd_pin = tx_bit;
    supply_uv = !reg_on;
  end
endmodule // cpg_mcu_model
